// ===== rtl/ffmd_top.sv
// Freefall/motion event detector with an AHB-Lite register slave.
// Assumes one 100 MHz clock and samples written by software over the bus.
`timescale 1ns/1ps
`include "ffmd_defines.svh"

module ffmd_top
    import ffmd_pkg::*;
#(
    parameter int          SMP_W   = 12,
    parameter logic [31:0] ODR_DIV = `FFMD_ODR_DIV_RST
) (
    input  wire logic        clk_i,
    input  wire logic        srst_i,
    input  wire logic        hsel_i,
    input  wire logic [31:0] haddr_i,
    input  wire logic [1:0]  htrans_i,
    input  wire logic        hwrite_i,
    input  wire logic [2:0]  hsize_i,
    input  wire logic [31:0] hwdata_i,
    input  wire logic        hready_i,
    output logic      [31:0] hrdata_o,
    output logic             hreadyout_o,
    output logic             hresp_o,
    output logic             event_active_o
);

    // ======================================================================
    // Helpers
    function automatic logic [SMP_W-2:0] mag(input logic [SMP_W-1:0] s);
        logic [SMP_W-1:0] a;
        a = s[SMP_W-1] ? (~s + 1'b1) : s;
        return (a[SMP_W-1]) ? {(SMP_W-1){1'b1}} : a[SMP_W-2:0];
    endfunction

    // Threshold is 7 bits, compared against the top magnitude bits
    function automatic logic above(input logic [SMP_W-1:0] s, input logic [6:0] t);
        logic [SMP_W-2:0] m;
        m = mag(s);
        return m[SMP_W-2 -: 7] > t;
    endfunction

    // ======================================================================
    // Registers
    logic [7:0]       cfg_q;
    logic [7:0]       ths_q;
    logic [7:0]       cnt_set_q;
    logic [SMP_W-1:0] smp_q [3];
    logic [7:0]       dbc_q;
    logic             ea_q;
    logic [5:0]       axf_q;
    logic [31:0]      div_q;
    logic             odr_tick;

    logic             dph_q;
    logic             dph_wr_q;
    logic [7:0]       dph_addr_q;

    wire logic latch_en = cfg_q[`FFMD_CFG_LATCH_BIT];
    wire logic comb_sel = cfg_q[`FFMD_CFG_COMB_BIT];
    wire logic [2:0] axen = {cfg_q[`FFMD_CFG_ZEN_BIT], cfg_q[`FFMD_CFG_YEN_BIT],
                             cfg_q[`FFMD_CFG_XEN_BIT]};
    wire logic dbc_mode = ths_q[`FFMD_THS_MODE_BIT];

    ffmd_mode_t mode;
    always_comb begin
        mode = ffmd_mode_t'({comb_sel, latch_en});
    end

    // ======================================================================
    // AHB-Lite slave: zero wait state, OKAY only
    wire logic req = hsel_i && hready_i && htrans_i[1];
    wire logic src_rd = dph_q && !dph_wr_q && dph_addr_q == `FFMD_SRC_ADDR;

    assign hreadyout_o = 1'b1;
    assign hresp_o     = 1'b0;

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            dph_q      <= 1'b0;
            dph_wr_q   <= 1'b0;
            dph_addr_q <= 8'h00;
        end else if (hready_i) begin
            dph_q      <= req;
            dph_wr_q   <= hwrite_i;
            dph_addr_q <= haddr_i[7:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            cfg_q     <= `FFMD_CFG_RST;
            ths_q     <= `FFMD_THS_RST;
            cnt_set_q <= `FFMD_CNT_RST;
            for (int i = 0; i < 3; i++) smp_q[i] <= `FFMD_SMP_RST;
        end else if (dph_q && dph_wr_q) begin
            case (dph_addr_q)
                `FFMD_CFG_ADDR:   cfg_q     <= hwdata_i[7:0];
                `FFMD_THS_ADDR:   ths_q     <= hwdata_i[7:0];
                `FFMD_CNT_ADDR:   cnt_set_q <= hwdata_i[7:0];
                `FFMD_SMP_X_ADDR: smp_q[0]  <= hwdata_i[SMP_W-1:0];
                `FFMD_SMP_Y_ADDR: smp_q[1]  <= hwdata_i[SMP_W-1:0];
                `FFMD_SMP_Z_ADDR: smp_q[2]  <= hwdata_i[SMP_W-1:0];
                default: ;
            endcase
        end
    end

    // Read data registered in the address phase, so it stands in the data phase
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            hrdata_o <= 32'h0000_0000;
        end else if (req && !hwrite_i) begin
            case (haddr_i[7:0])
                `FFMD_CFG_ADDR: hrdata_o <= {24'h00_0000, cfg_q};
                `FFMD_SRC_ADDR: hrdata_o <= {24'h00_0000, ea_q, 1'b0, axf_q};
                `FFMD_THS_ADDR: hrdata_o <= {24'h00_0000, ths_q};
                `FFMD_CNT_ADDR: hrdata_o <= {24'h00_0000, cnt_set_q};
                default:        hrdata_o <= 32'h0000_0000;
            endcase
        end
    end

    // ======================================================================
    // Output data rate enable
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            div_q <= 32'h0000_0000;
        end else if (div_q >= ODR_DIV - 32'h1) begin
            div_q <= 32'h0000_0000;
        end else begin
            div_q <= div_q + 32'h1;
        end
    end
    assign odr_tick = (div_q >= ODR_DIV - 32'h1);

    // ======================================================================
    // Axis comparison and combination
    logic [2:0] hi;
    logic [5:0] live_flags;
    logic       motion_c;
    logic       free_c;
    logic       cond;

    always_comb begin
        for (int i = 0; i < 3; i++) begin
            hi[i] = above(smp_q[i], ths_q[6:0]);
            live_flags[2*i+1] = axen[i] & hi[i];
            live_flags[2*i]   = axen[i] & smp_q[i][SMP_W-1];
        end
        motion_c = |(axen & hi);
        free_c   = ((axen & hi) == 3'b000);
        // Disabled detector never sees a condition
        cond = (axen != 3'b000) && (comb_sel ? motion_c : free_c);
    end

    // ======================================================================
    // Debounce counter and event flag
    wire logic latched_clr = latch_en && src_rd;

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            dbc_q <= 8'h00;
        end else if (latched_clr) begin
            dbc_q <= 8'h00;
        end else if (odr_tick) begin
            if (cond) begin
                if (dbc_q < cnt_set_q) dbc_q <= dbc_q + 8'h01;
            end else if (dbc_mode) begin
                dbc_q <= 8'h00;
            end else if (dbc_q != 8'h00) begin
                dbc_q <= dbc_q - 8'h01;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            ea_q <= 1'b0;
        end else if (latched_clr) begin
            ea_q <= 1'b0;
        end else if (odr_tick) begin
            if (cond && (dbc_q >= cnt_set_q || dbc_q + 8'h01 == cnt_set_q)) begin
                ea_q <= 1'b1;
            end else if (!latch_en && !cond) begin
                // Mode 1 clears at once; mode 0 waits for decrement to zero
                if (dbc_mode || dbc_q <= 8'h01) ea_q <= 1'b0;
            end
        end
    end

    // Per-axis flags: live while no latched event is held
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            axf_q <= 6'h00;
        end else if (latched_clr) begin
            axf_q <= 6'h00;
        end else if (!(latch_en && ea_q)) begin
            axf_q <= live_flags;
        end
    end

    assign event_active_o = ea_q;

    // ======================================================================
    // Checks
    // Software may rewrite the configuration at any edge, so properties that
    // compare against the live decode first require it to have stood still.
    sequence latched_read_s;
        latched_clr;
    endsequence

    sequence live_read_s;
        src_rd && !latch_en && !odr_tick;
    endsequence

    sequence fast_drop_s;
        !latch_en && dbc_mode && odr_tick && !cond;
    endsequence

    sequence slow_drop_s;
        !latch_en && !dbc_mode && odr_tick && !cond;
    endsequence

    // Bus side: never a wait state, never an error
    bus_ok_a: assert property (@(posedge clk_i) disable iff (srst_i)
        hreadyout_o && !hresp_o)
        else $error("bus answer not ready and okay");

    // Read-clear behaviour of the source register
    src_clear_a: assert property (@(posedge clk_i) disable iff (srst_i)
        latched_read_s |=> !ea_q && dbc_q == 8'h00 && axf_q == 6'h00)
        else $error("latched read did not clear");

    // Counter restarts at zero, so one more edge cannot reach a count above one
    rearm_wait_a: assert property (@(posedge clk_i) disable iff (srst_i)
        latched_clr && cnt_set_q > 8'h01 |=> !ea_q ##1 !ea_q)
        else $error("event raised again before debounce");

    live_read_a: assert property (@(posedge clk_i) disable iff (srst_i)
        live_read_s |=> $stable(ea_q))
        else $error("live read changed event flag");

    motion_read_a: assert property (@(posedge clk_i) disable iff (srst_i)
        live_read_s ##0 comb_sel |=> $stable(dbc_q) && $stable(ea_q))
        else $error("live motion read touched counter");

    // Latched hold and freeze
    latch_hold_a: assert property (@(posedge clk_i) disable iff (srst_i)
        latch_en && ea_q && !src_rd && $stable(cfg_q) |=> ea_q)
        else $error("latched flag dropped without read");

    freeze_a: assert property (@(posedge clk_i) disable iff (srst_i)
        latch_en && ea_q && !src_rd |=> $stable(axf_q))
        else $error("latched axis flags changed");

    // Enables and mode decode
    disabled_a: assert property (@(posedge clk_i) disable iff (srst_i)
        axen == 3'b000 && !ea_q && $stable(cfg_q) |=> !ea_q)
        else $error("disabled detector raised event");

    no_cond_a: assert property (@(posedge clk_i) disable iff (srst_i)
        axen == 3'b000 |-> !cond)
        else $error("disabled detector saw a condition");

    mode_map_a: assert property (@(posedge clk_i) disable iff (srst_i)
        (mode == FFMD_MOTION_LATCH) == (latch_en && comb_sel)
        && (mode == FFMD_FREEFALL_LIVE) == (!latch_en && !comb_sel))
        else $error("mode decode wrong");

    // Live per-axis flags; a changed sample or enable needs one edge to settle
    live_axis_a: assert property (@(posedge clk_i) disable iff (srst_i)
        !(latch_en && ea_q) && !src_rd ##1 $stable(smp_q[0]) && $stable(cfg_q)
        && $stable(ths_q) |-> axf_q[1] == (axen[0] & hi[0]))
        else $error("x high flag not live");

    polarity_a: assert property (@(posedge clk_i) disable iff (srst_i)
        !(latch_en && ea_q) && !src_rd ##1 $stable(smp_q[1]) && $stable(cfg_q)
        |-> axf_q[2] == (axen[1] & smp_q[1][SMP_W-1]))
        else $error("y polarity flag wrong");

    axis_zero_a: assert property (@(posedge clk_i) disable iff (srst_i)
        !axen[2] && !(latch_en && ea_q) |=> axf_q[5:4] == 2'b00)
        else $error("disabled z axis flags set");

    // Non-latched release, debounce mode 1: drop and restart at once
    quick_clear_a: assert property (@(posedge clk_i) disable iff (srst_i)
        fast_drop_s |=> !ea_q)
        else $error("mode 1 flag not cleared");

    fast_rearm_a: assert property (@(posedge clk_i) disable iff (srst_i)
        fast_drop_s |=> dbc_q == 8'h00)
        else $error("mode 1 counter not restarted");

    // Non-latched release, debounce mode 0: count down, drop at the end
    slow_hold_a: assert property (@(posedge clk_i) disable iff (srst_i)
        slow_drop_s ##0 ea_q && dbc_q > 8'h01 |=> ea_q)
        else $error("mode 0 flag dropped early");

    count_down_a: assert property (@(posedge clk_i) disable iff (srst_i)
        slow_drop_s ##0 dbc_q != 8'h00 |=> dbc_q == $past(dbc_q) - 8'h01)
        else $error("mode 0 counter did not step down");

    slow_end_a: assert property (@(posedge clk_i) disable iff (srst_i)
        slow_drop_s ##0 dbc_q <= 8'h01 |=> !ea_q)
        else $error("mode 0 flag not dropped at end");

    // Debounce count up and set
    count_step_a: assert property (@(posedge clk_i) disable iff (srst_i)
        odr_tick && cond && !latched_clr && dbc_q < cnt_set_q
        |=> dbc_q == $past(dbc_q) + 8'h01)
        else $error("counter did not step up");

    count_set_a: assert property (@(posedge clk_i) disable iff (srst_i)
        $rose(ea_q) |-> $past(cond) && $past(odr_tick))
        else $error("flag rose without debounced condition");

    // Axis combination
    combine_a: assert property (@(posedge clk_i) disable iff (srst_i)
        comb_sel && axen != 3'b000 |-> cond == |(axen & hi))
        else $error("motion combine wrong");

    free_combine_a: assert property (@(posedge clk_i) disable iff (srst_i)
        !comb_sel && axen != 3'b000 |-> cond == ((axen & hi) == 3'b000))
        else $error("freefall combine wrong");

endmodule

// ===== rtl/ffmd_defines.svh
// Constants for the freefall/motion detector: register offsets, fields, resets.
// Assumes inclusion by bare name from the package and the design module.
`ifndef FFMD_DEFINES_SVH
`define FFMD_DEFINES_SVH

// ==========================================================================
// Register byte offsets
`define FFMD_CFG_ADDR      8'h54
`define FFMD_SRC_ADDR      8'h58
`define FFMD_THS_ADDR      8'h5C
`define FFMD_CNT_ADDR      8'h60
`define FFMD_SMP_X_ADDR    8'h64
`define FFMD_SMP_Y_ADDR    8'h68
`define FFMD_SMP_Z_ADDR    8'h6C

// ==========================================================================
// Register fields: configuration, threshold mode, source event
`define FFMD_CFG_LATCH_BIT 7
`define FFMD_CFG_COMB_BIT  6
`define FFMD_CFG_ZEN_BIT   5
`define FFMD_CFG_YEN_BIT   4
`define FFMD_CFG_XEN_BIT   3
`define FFMD_THS_MODE_BIT  7
`define FFMD_SRC_EA_BIT    7

// ==========================================================================
// Reset values
`define FFMD_CFG_RST       8'h00
`define FFMD_THS_RST       8'h00
`define FFMD_CNT_RST       8'h00
`define FFMD_SMP_RST       12'h000
`define FFMD_ODR_DIV_RST   32'd1000

`endif

// ===== rtl/ffmd_pkg.sv
// Types shared by the freefall/motion detector.
// Assumes the defines header is on the include path.
package ffmd_pkg;
    `include "ffmd_defines.svh"

    typedef enum logic [1:0] {
        FFMD_FREEFALL_LIVE,
        FFMD_FREEFALL_LATCH,
        FFMD_MOTION_LIVE,
        FFMD_MOTION_LATCH
    } ffmd_mode_t;
endpackage

// ===== tb/ffmd_host.sv
// Host model: AHB-Lite master reaching the detector's registers.
// Assumes one slave whose hreadyout is fed back as hready.
`timescale 1ns/1ps

module ffmd_host (
    input  wire logic        clk_i,
    input  wire logic        hready_i,
    input  wire logic [31:0] hrdata_i,
    output logic             hsel_o,
    output logic [31:0]      haddr_o,
    output logic [1:0]       htrans_o,
    output logic             hwrite_o,
    output logic [2:0]       hsize_o,
    output logic [31:0]      hwdata_o
);
    initial begin
        hsel_o   = 1'b0;
        haddr_o  = 32'h0;
        htrans_o = 2'h0;
        hwrite_o = 1'b0;
        hsize_o  = 3'h2;
        hwdata_o = 32'h0;
    end

    // ======================================================================
    // Single word transfer, entered just after a rising edge
    task automatic xfer(input logic wr, input logic [7:0] adr,
                        input logic [31:0] wd, output logic [31:0] rd);
        hsel_o   <= 1'b1;
        haddr_o  <= {24'h0, adr};
        htrans_o <= 2'h2;
        hwrite_o <= wr;
        hsize_o  <= 3'h2;
        do @(posedge clk_i); while (hready_i !== 1'b1);
        hsel_o   <= 1'b0;
        htrans_o <= 2'h0;
        hwdata_o <= wd;
        do @(posedge clk_i); while (hready_i !== 1'b1);
        rd = hrdata_i;
        // Stale data must not look valid after the data phase
        hwdata_o <= ~wd;
    endtask
endmodule

// ===== tb/tb_top.sv
// Testbench for the freefall/motion detector: mode scenarios over AHB-Lite.
// Assumes ODR_DIV of 4 clocks per sample tick and a 100 MHz clock.
`timescale 1ns/1ps
`include "ffmd_defines.svh"

module tb_top;
    import ffmd_pkg::*;
    logic        clk = 1'b0;
    logic        srst = 1'b1;
    logic        hsel, hwrite, hready, hresp, ea;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    int          mismatches = 0;
    int          total_checks = 0;

    always #5 clk = ~clk;

    ffmd_host host (.clk_i(clk), .hready_i(hready), .hrdata_i(hrdata), .hsel_o(hsel),
        .haddr_o(haddr), .htrans_o(htrans), .hwrite_o(hwrite), .hsize_o(hsize),
        .hwdata_o(hwdata));
    ffmd_top #(.ODR_DIV(32'd4)) dut (.clk_i(clk), .srst_i(srst), .hsel_i(hsel),
        .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize),
        .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready),
        .hresp_o(hresp), .event_active_o(ea));

    // ======================================================================
    // Shared helpers
    task automatic tk(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] v;
        host.xfer(1'b1, a, d, v);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] v;
        host.xfer(1'b0, a, 32'h0, v);
        chk("read data", exp, v);
    endtask
    task automatic eq(input logic exp);
        chk("event active", {31'h0, exp}, {31'h0, ea});
    endtask
    task automatic rst;
        srst <= 1'b1;
        tk(3);
        srst <= 1'b0;
        tk(1);
    endtask

    // ======================================================================
    // Scenarios
    task automatic t_idle;
        rst();
        wr(8'h00, 32'h0000_00FF);
        rd(8'h00, 32'h0);
        tk(40);
        eq(1'b0);
        rd(`FFMD_SRC_ADDR, 32'h0);
        chk("bus response", 32'h0, {31'h0, hresp});
    endtask
    task automatic t_motion_latch;
        rst();
        wr(`FFMD_THS_ADDR, 32'h08);
        wr(`FFMD_CNT_ADDR, 32'h02);
        wr(`FFMD_CFG_ADDR, 32'hD8);
        rd(`FFMD_CFG_ADDR, 32'hD8);
        wr(`FFMD_SMP_X_ADDR, 32'hF00);
        eq(1'b0);
        tk(40);
        eq(1'b1);
        wr(`FFMD_SMP_Y_ADDR, 32'h100);
        rd(`FFMD_SRC_ADDR, 32'h83);
        tk(1);
        eq(1'b0);
        rd(`FFMD_SRC_ADDR, 32'h0B);
    endtask
    task automatic t_freefall_live;
        rst();
        wr(`FFMD_THS_ADDR, 32'h88);
        wr(`FFMD_CNT_ADDR, 32'h01);
        wr(`FFMD_CFG_ADDR, 32'h38);
        tk(40);
        eq(1'b1);
        rd(`FFMD_SRC_ADDR, 32'h80);
        eq(1'b1);
        wr(`FFMD_SMP_X_ADDR, 32'h100);
        tk(8);
        eq(1'b0);
        rd(`FFMD_SRC_ADDR, 32'h02);
        wr(`FFMD_THS_ADDR, 32'h08);
        wr(`FFMD_CNT_ADDR, 32'h03);
        wr(`FFMD_SMP_X_ADDR, 32'h0);
        tk(40);
        eq(1'b1);
        wr(`FFMD_SMP_X_ADDR, 32'h100);
        tk(6);
        eq(1'b1);
        tk(40);
        eq(1'b0);
    endtask
    task automatic t_motion_live;
        rst();
        wr(`FFMD_THS_ADDR, 32'h08);
        wr(`FFMD_CNT_ADDR, 32'h03);
        wr(`FFMD_CFG_ADDR, 32'h50);
        wr(`FFMD_SMP_X_ADDR, 32'h100);
        tk(40);
        eq(1'b0);
        rd(`FFMD_SRC_ADDR, 32'h0);
        wr(`FFMD_SMP_Y_ADDR, 32'hF00);
        tk(40);
        rd(`FFMD_SRC_ADDR, 32'h8C);
        rd(`FFMD_SRC_ADDR, 32'h8C);
        wr(`FFMD_SMP_Y_ADDR, 32'h0);
        tk(6);
        eq(1'b1);
        tk(100);
        eq(1'b0);
        wr(`FFMD_THS_ADDR, 32'h88);
        wr(`FFMD_SMP_Y_ADDR, 32'h100);
        tk(40);
        eq(1'b1);
        wr(`FFMD_SMP_Y_ADDR, 32'h0);
        tk(8);
        eq(1'b0);
    endtask

    // ======================================================================
    // Run control
    task automatic conclude;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    initial begin
        rst();
        t_idle();
        t_motion_latch();
        t_freefall_live();
        t_motion_live();
        conclude();
    end

    // Whole run needs well under 2000 cycles
    initial begin
        #100000;
        mismatches++;
        conclude();
    end
endmodule
